// ---- design/csps_mapper.sv ----
// CAN signal packing, receive extraction and source selection with AXI4-Lite setup
`timescale 1ns/1ps
`default_nettype none
module csps_mapper import csps_pkg::*; #(
	parameter int NRX       = CSPS_NRX,
	parameter int NTX       = CSPS_NTX,
	parameter int MS_CYCLES = CSPS_MS_CYC,
	parameter int HOLD_MS   = CSPS_HOLD_MS
) (
	input  wire logic                    clk,
	input  wire logic                    rstn,
	input  wire logic [CSPS_ADDR_W-1:0]  s_axi_awaddr,
	input  wire logic                    s_axi_awvalid,
	output var  logic                    s_axi_awready,
	input  wire logic [31:0]             s_axi_wdata,
	input  wire logic [3:0]              s_axi_wstrb,
	input  wire logic                    s_axi_wvalid,
	output var  logic                    s_axi_wready,
	output var  logic [1:0]              s_axi_bresp,
	output var  logic                    s_axi_bvalid,
	input  wire logic                    s_axi_bready,
	input  wire logic [CSPS_ADDR_W-1:0]  s_axi_araddr,
	input  wire logic                    s_axi_arvalid,
	output var  logic                    s_axi_arready,
	output var  logic [31:0]             s_axi_rdata,
	output var  logic [1:0]              s_axi_rresp,
	output var  logic                    s_axi_rvalid,
	input  wire logic                    s_axi_rready,
	input  wire logic [CSPS_NCODE-1:0][15:0][15:0] ext_val,
	input  wire logic [7:0]              supply_v,
	input  wire logic [7:0]              cpu_temp,
	input  wire logic [1:0]              rx_valid,
	input  wire csps_frame_t [1:0]       rx_frame,
	output var  logic                    tx_valid,
	output var  logic                    tx_if,
	output var  csps_frame_t             tx_frame,
	input  wire logic                    tx_ready,
	output var  logic [NRX-1:0]          rx_lost,
	output var  logic [NRX-1:0]          rx_dig
);
	logic [1:0]  rst_q;
	logic        rst_n_s;
	logic [31:0] cfg [CSPS_NWORD];
	logic [31:0] ms_cnt;
	logic        ms_tick;
	logic [15:0] hold_cnt;
	logic        hold_done;
	logic        aw_got;
	logic        w_got;
	logic [CSPS_ADDR_W-1:0] aw_q;
	logic [31:0] w_q;
	logic [3:0]  s_q;
	logic        do_wr;
	logic        next_aw_got;
	logic        next_w_got;
	logic        next_bvalid;
	logic        next_rvalid;
	int          wr_idx;
	logic [15:0] rx_val [NRX];
	logic [15:0] rx_ext [NRX];
	logic [15:0] rx_cnt [NRX];
	logic [NRX-1:0] rx_hit;
	logic [63:0] tx_pay [NTX];
	logic [63:0] grp_pay [NTX];
	logic [15:0] tx_cnt [NTX];
	logic [NTX-1:0] lead;
	logic [NTX-1:0] armed;
	logic [NTX-1:0] due;
	logic [NTX-1:0] pend;
	logic [NTX-1:0] take;
	int          pick;

	function automatic int rx_base(input int i);
		rx_base = CSPS_W_RXCFG + i * CSPS_RX_STRIDE;
	endfunction : rx_base

	function automatic int tx_base(input int m);
		tx_base = CSPS_W_TXCFG + m * CSPS_TX_STRIDE;
	endfunction : tx_base

	function automatic logic [63:0] fmask(input logic [4:0] n);
		fmask = (64'h1 << n) - 64'h1;
	endfunction : fmask

	function automatic logic in_cfg(input int w);
		in_cfg = (w >= CSPS_W_CONST && w < CSPS_W_CONST + CSPS_NCONST)
			|| (w >= CSPS_W_RXCFG && w < rx_base(NRX))
			|| (w >= CSPS_W_TXCFG && w < tx_base(NTX));
	endfunction : in_cfg

	function automatic logic [31:0] rd_word(input int w);
		int k;
		k = w - CSPS_W_RXSTAT;
		rd_word = 32'h0;
		if (w == CSPS_W_STAT)
			rd_word = {31'h0, hold_done};
		else if (k >= 0 && k < NRX)
			rd_word = {14'h0, rx_dig[k], rx_lost[k], rx_val[k]};
		else if (in_cfg(w))
			rd_word = cfg[w];
	endfunction : rd_word

	function automatic logic rd_ok(input int w);
		rd_ok = w == CSPS_W_STAT || in_cfg(w)
			|| (w >= CSPS_W_RXSTAT && w < CSPS_W_RXSTAT + NRX);
	endfunction : rd_ok

	// Numbers are 1-based and out-of-range give zero; supply and temperature use the number as a threshold
	function automatic logic [15:0] src_val(input logic [4:0] code, input logic [7:0] num);
		logic [3:0] k;
		k = 4'(num - 8'h01);
		src_val = 16'h0;
		case (code)
			CSPS_SRC_UNUSED, CSPS_SRC_RXTMO: src_val = 16'h0;
			CSPS_SRC_RXMSG: begin
				if (num >= 8'h01 && int'(num) <= NRX)
					src_val = rx_val[k];
			end
			CSPS_SRC_CONST: begin
				if (num == 8'h02)
					src_val = 16'h1;
				else if (int'(num) >= CSPS_CONST_LO && int'(num) < CSPS_CONST_LO + CSPS_NCONST)
					src_val = cfg[CSPS_W_CONST + int'(num) - CSPS_CONST_LO][15:0];
			end
			CSPS_SRC_SUPPLY: src_val = {15'h0, supply_v >= num};
			CSPS_SRC_TEMP: src_val = {15'h0, cpu_temp >= num};
			default: begin
				if (int'(code) < CSPS_NCODE && num >= 8'h01 && num <= 8'h10)
					src_val = ext_val[code][k];
			end
		endcase
	endfunction : src_val

	function automatic logic [63:0] tx_field(input csps_sig_t sg, input csps_scale_t sc);
		logic [15:0] v;
		logic [31:0] prod;
		v = src_val(sg.code, sg.num) - sc.off;
		prod = {16'h0, v} * {16'h0, sc.res};
		tx_field = 64'(prod >> CSPS_FRAC) & fmask(sg.size);
		tx_field = tx_field << {sg.bytex, sg.bitx};
		if (sg.code == CSPS_SRC_UNUSED)
			tx_field = 64'h0;
	endfunction : tx_field

	function automatic logic [15:0] rx_extract(input csps_place_t p, input csps_scale_t sc,
			input logic [63:0] d);
		logic [63:0] raw;
		logic [31:0] prod;
		raw = (d >> {p.bytex, p.bitx}) & fmask(p.size);
		prod = raw[31:0] * {16'h0, sc.res};
		rx_extract = 16'(prod >> CSPS_FRAC) + sc.off;
	endfunction : rx_extract

	// Reset is asserted at once but released through two flops
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			rst_q <= 2'h0;
		else
			rst_q <= {rst_q[0], 1'b1};
	end
	assign rst_n_s = rst_q[1];

	always_ff @(posedge clk or negedge rst_n_s) begin
		if (!rst_n_s) begin
			ms_cnt <= 32'h0;
			ms_tick <= 1'b0;
		end else begin
			ms_tick <= ms_cnt == 32'(MS_CYCLES - 1);
			ms_cnt <= (ms_cnt == 32'(MS_CYCLES - 1)) ? 32'h0 : ms_cnt + 32'h1;
		end
	end

	always_ff @(posedge clk or negedge rst_n_s) begin
		if (!rst_n_s) begin
			hold_cnt <= 16'h0;
			hold_done <= 1'b0;
		end else if (ms_tick && !hold_done) begin
			hold_cnt <= hold_cnt + 16'h1;
			hold_done <= hold_cnt == 16'(HOLD_MS - 1);
		end
	end

	// AXI4-Lite slave: address and data may arrive in either order
	assign do_wr = aw_got && w_got && !s_axi_bvalid;
	assign next_aw_got = aw_got ? !do_wr : (s_axi_awvalid && s_axi_awready);
	assign next_w_got = w_got ? !do_wr : (s_axi_wvalid && s_axi_wready);
	assign next_bvalid = s_axi_bvalid ? !s_axi_bready : do_wr;
	assign next_rvalid = s_axi_rvalid ? !s_axi_rready : (s_axi_arvalid && s_axi_arready);
	assign wr_idx = int'(aw_q[CSPS_ADDR_W-1:2]);

	always_ff @(posedge clk or negedge rst_n_s) begin
		if (!rst_n_s) begin
			aw_got <= 1'b0;
			w_got <= 1'b0;
			aw_q <= '0;
			w_q <= 32'h0;
			s_q <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= CSPS_RESP_OKAY;
		end else begin
			aw_got <= next_aw_got;
			w_got <= next_w_got;
			s_axi_bvalid <= next_bvalid;
			s_axi_awready <= !next_aw_got && !next_bvalid;
			s_axi_wready <= !next_w_got && !next_bvalid;
			if (s_axi_awvalid && s_axi_awready)
				aw_q <= s_axi_awaddr;
			if (s_axi_wvalid && s_axi_wready) begin
				w_q <= s_axi_wdata;
				s_q <= s_axi_wstrb;
			end
			if (do_wr)
				s_axi_bresp <= rd_ok(wr_idx) ? CSPS_RESP_OKAY : CSPS_RESP_DEC;
		end
	end

	// Zero after reset leaves every receive message off and every signal unused
	always_ff @(posedge clk or negedge rst_n_s) begin
		if (!rst_n_s) begin
			for (int w = 0; w < CSPS_NWORD; w++)
				cfg[w] <= 32'h0;
		end else if (do_wr && in_cfg(wr_idx)) begin
			for (int b = 0; b < 4; b++)
				if (s_q[b])
					cfg[wr_idx][8*b +: 8] <= w_q[8*b +: 8];
		end
	end

	always_ff @(posedge clk or negedge rst_n_s) begin
		if (!rst_n_s) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= CSPS_RESP_OKAY;
		end else begin
			s_axi_rvalid <= next_rvalid;
			s_axi_arready <= !next_rvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rdata <= rd_word(int'(s_axi_araddr[CSPS_ADDR_W-1:2]));
				s_axi_rresp <= rd_ok(int'(s_axi_araddr[CSPS_ADDR_W-1:2]))
					? CSPS_RESP_OKAY : CSPS_RESP_DEC;
			end
		end
	end

	// Receive match and extraction, one definition per message
	always_comb begin
		for (int i = 0; i < NRX; i++) begin
			csps_rxw0_t c0;
			csps_place_t pl;
			csps_frame_t f;
			logic pdu1;
			c0 = cfg[rx_base(i)];
			pl = cfg[rx_base(i) + 1];
			f = rx_frame[c0.ifsel];
			pdu1 = pl.pgn[15:8] < CSPS_PDU2_PF;
			rx_hit[i] = c0.en && rx_valid[c0.ifsel] && f.pgn == pl.pgn
				&& (!pdu1 || c0.sa == CSPS_SA_ANY || c0.sa == f.sa);
			rx_ext[i] = rx_extract(pl, cfg[rx_base(i) + 2], f.data);
		end
	end

	// An arrival in the tick's cycle restarts supervision rather than faulting
	always_ff @(posedge clk or negedge rst_n_s) begin
		if (!rst_n_s) begin
			for (int i = 0; i < NRX; i++) begin
				rx_val[i] <= 16'h0;
				rx_cnt[i] <= 16'h0;
			end
			rx_lost <= '0;
		end else begin
			for (int i = 0; i < NRX; i++) begin
				csps_rxw0_t c0;
				c0 = cfg[rx_base(i)];
				if (!c0.en) begin
					rx_cnt[i] <= 16'h0;
					rx_lost[i] <= 1'b0;
				end else if (rx_hit[i]) begin
					rx_val[i] <= rx_ext[i];
					rx_cnt[i] <= 16'h0;
					rx_lost[i] <= 1'b0;
				end else if (c0.tmo == 16'h0) begin
					rx_cnt[i] <= 16'h0;
					rx_lost[i] <= 1'b0;
				end else if (ms_tick) begin
					if (rx_cnt[i] >= c0.tmo - 16'h1)
						rx_lost[i] <= 1'b1;
					else
						rx_cnt[i] <= rx_cnt[i] + 16'h1;
				end
			end
		end
	end

	// Between min and max the digital reading keeps its last state
	always_ff @(posedge clk or negedge rst_n_s) begin
		if (!rst_n_s)
			rx_dig <= '0;
		else begin
			for (int i = 0; i < NRX; i++) begin
				csps_range_t rg;
				rg = cfg[rx_base(i) + 3];
				if (rx_val[i] <= rg.min)
					rx_dig[i] <= 1'b0;
				else if (rx_val[i] >= rg.max)
					rx_dig[i] <= 1'b1;
			end
		end
	end

	// Overlapping fields simply OR together; nothing guards against it
	always_comb begin
		for (int m = 0; m < NTX; m++) begin
			tx_pay[m] = 64'h0;
			for (int s = 0; s < CSPS_NSIG; s++)
				tx_pay[m] = tx_pay[m] | tx_field(cfg[tx_base(m) + CSPS_TX_SIG + 2*s],
					cfg[tx_base(m) + CSPS_TX_SIG + 2*s + 1]);
		end
		for (int m = 0; m < NTX; m++) begin
			csps_txw0_t a;
			a = cfg[tx_base(m)];
			lead[m] = 1'b1;
			grp_pay[m] = 64'h0;
			for (int j = 0; j < NTX; j++) begin
				csps_txw0_t b;
				b = cfg[tx_base(j)];
				if (b.pgn == a.pgn) begin
					if (j < m)
						lead[m] = 1'b0;
					else
						grp_pay[m] = grp_pay[m] | tx_pay[j];
				end
			end
			armed[m] = lead[m] && cfg[tx_base(m) + 1][15:0] != 16'h0 && hold_done;
			due[m] = armed[m] && ms_tick && tx_cnt[m] >= cfg[tx_base(m) + 1][15:0] - 16'h1;
		end
	end

	always_ff @(posedge clk or negedge rst_n_s) begin
		if (!rst_n_s) begin
			for (int m = 0; m < NTX; m++)
				tx_cnt[m] <= 16'h0;
		end else begin
			for (int m = 0; m < NTX; m++)
				if (!armed[m] || due[m])
					tx_cnt[m] <= 16'h0;
				else if (ms_tick)
					tx_cnt[m] <= tx_cnt[m] + 16'h1;
		end
	end

	// Lowest-numbered pending message goes first
	always_comb begin
		pick = 0;
		take = '0;
		for (int m = NTX - 1; m >= 0; m--)
			if (pend[m])
				pick = m;
		if ((!tx_valid || tx_ready) && |pend)
			take[pick] = 1'b1;
	end

	// A new period landing on the send cycle is kept, not lost
	always_ff @(posedge clk or negedge rst_n_s) begin
		if (!rst_n_s)
			pend <= '0;
		else
			pend <= due | (pend & ~take);
	end

	always_ff @(posedge clk or negedge rst_n_s) begin
		if (!rst_n_s) begin
			tx_valid <= 1'b0;
			tx_if <= 1'b0;
			tx_frame <= '0;
		end else if (!tx_valid || tx_ready) begin
			tx_valid <= |pend;
			if (|pend) begin
				csps_txw0_t a;
				a = cfg[tx_base(pick)];
				tx_if <= a.ifsel;
				tx_frame <= {a.pgn, 8'h00, grp_pay[pick]};
			end
		end
	end
endmodule : csps_mapper
`default_nettype wire

// ---- design/csps_pkg.sv ----
// Constants, register map and carrier types of the CAN signal packing and source select block
package csps_pkg;
	localparam int CSPS_CLK_NS   = 100;
	localparam int CSPS_MS_NS    = 1000000;
	localparam int CSPS_MS_CYC   = (CSPS_MS_NS + CSPS_CLK_NS - 1) / CSPS_CLK_NS;
	localparam int CSPS_HOLD_MS  = 5000;
	localparam int CSPS_NRX      = 9;
	localparam int CSPS_NTX      = 11;
	localparam int CSPS_NSIG     = 4;
	localparam int CSPS_NCODE    = 18;
	localparam int CSPS_FRAC     = 8;
	localparam int CSPS_ADDR_W   = 10;
	localparam int CSPS_NWORD    = 256;
	localparam int CSPS_W_STAT   = 0;
	localparam int CSPS_W_CONST  = 1;
	localparam int CSPS_NCONST   = 13;
	localparam int CSPS_CONST_LO = 3;
	localparam int CSPS_W_RXCFG  = 16;
	localparam int CSPS_RX_STRIDE = 4;
	localparam int CSPS_W_RXSTAT = 64;
	localparam int CSPS_W_TXCFG  = 80;
	localparam int CSPS_TX_STRIDE = 10;
	localparam int CSPS_TX_SIG   = 2;
	localparam logic [7:0] CSPS_SA_ANY  = 8'hFF;
	localparam logic [7:0] CSPS_PDU2_PF = 8'hF0;
	localparam logic [4:0] CSPS_SRC_UNUSED = 5'h00;
	localparam logic [4:0] CSPS_SRC_RXMSG  = 5'h01;
	localparam logic [4:0] CSPS_SRC_CONST  = 5'h0B;
	localparam logic [4:0] CSPS_SRC_SUPPLY = 5'h0E;
	localparam logic [4:0] CSPS_SRC_TEMP   = 5'h0F;
	localparam logic [4:0] CSPS_SRC_RXTMO  = 5'h10;
	localparam logic [1:0] CSPS_RESP_OKAY  = 2'h0;
	localparam logic [1:0] CSPS_RESP_DEC   = 2'h3;

	typedef struct packed {
		logic [17:0] pgn;
		logic [7:0]  sa;
		logic [63:0] data;
	} csps_frame_t;

	typedef struct packed {
		logic [15:0] tmo;
		logic [7:0]  sa;
		logic [5:0]  rsv;
		logic        ifsel;
		logic        en;
	} csps_rxw0_t;

	typedef struct packed {
		logic [2:0]  rsv;
		logic [2:0]  bytex;
		logic [2:0]  bitx;
		logic [4:0]  size;
		logic [17:0] pgn;
	} csps_place_t;

	typedef struct packed {
		logic [15:0] off;
		logic [15:0] res;
	} csps_scale_t;

	typedef struct packed {
		logic [15:0] max;
		logic [15:0] min;
	} csps_range_t;

	typedef struct packed {
		logic [6:0]  rsv;
		logic        ifsel;
		logic [5:0]  rsv2;
		logic [17:0] pgn;
	} csps_txw0_t;

	typedef struct packed {
		logic [4:0] rsv;
		logic [2:0] bytex;
		logic [2:0] bitx;
		logic [4:0] size;
		logic [7:0] num;
		logic [2:0] rsv2;
		logic [4:0] code;
	} csps_sig_t;
endpackage : csps_pkg

// ---- tb/csps_can_node.sv ----
// Behavioural model of the other CAN nodes on both interfaces
`timescale 1ns/1ps
`default_nettype none
module csps_can_node import csps_pkg::*; (
	input  wire logic              clk,
	output var  logic [1:0]        rx_valid,
	output var  csps_frame_t [1:0] rx_frame,
	input  wire logic              tx_valid,
	input  wire logic              tx_if,
	input  wire csps_frame_t       tx_frame,
	output var  logic              tx_ready
);
	logic        slow = 1'b0;
	logic [1:0]  pace = 2'h0;
	int          n_tx = 0;
	logic        got_if;
	csps_frame_t got;
	initial begin
		rx_valid = 2'h0;
		rx_frame = '0;
		tx_ready = 1'b0;
	end
	// A slow node takes a frame only every fourth cycle
	always @(posedge clk) begin
		pace     <= pace + 2'h1;
		tx_ready <= !slow || pace == 2'h3;
		if (tx_valid && tx_ready) begin
			got    <= tx_frame;
			got_if <= tx_if;
			n_tx   <= n_tx + 1;
		end
	end
	// Idle lines show the inverse so stale data never passes for a frame
	task automatic send(input int i, input csps_frame_t f);
		@(posedge clk);
		rx_valid[i] <= 1'b1;
		rx_frame[i] <= f;
		@(posedge clk);
		rx_valid[i] <= 1'b0;
		rx_frame[i] <= ~f;
	endtask : send
endmodule : csps_can_node
`default_nettype wire

// ---- tb/csps_mapper_assertions.sv ----
// Port-level checks of the CAN signal mapper
`timescale 1ns/1ps
`default_nettype none
module csps_mapper_assertions import csps_pkg::*; #(
	parameter int NRX       = CSPS_NRX,
	parameter int MS_CYCLES = CSPS_MS_CYC,
	parameter int HOLD_MS   = CSPS_HOLD_MS
) (
	input wire logic           clk,
	input wire logic           rstn,
	input wire logic           s_axi_awvalid,
	input wire logic           s_axi_awready,
	input wire logic           s_axi_wvalid,
	input wire logic           s_axi_wready,
	input wire logic           s_axi_bvalid,
	input wire logic           s_axi_bready,
	input wire logic           s_axi_arvalid,
	input wire logic           s_axi_arready,
	input wire logic           s_axi_rvalid,
	input wire logic           s_axi_rready,
	input wire logic           tx_valid,
	input wire logic           tx_if,
	input wire csps_frame_t    tx_frame,
	input wire logic           tx_ready,
	input wire logic [NRX-1:0] rx_lost,
	input wire logic [NRX-1:0] rx_dig
);
	localparam int HOLD = MS_CYCLES * HOLD_MS;
	int   age;
	logic wrote;
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	// Counts from rstn release; the internal release lags two edges, so this errs safe
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			age   <= 0;
			wrote <= 1'b0;
		end else begin
			age   <= (age < HOLD) ? age + 1 : age;
			wrote <= wrote | s_axi_bvalid;
		end
	end
	a_hold_quiet: assert property (age < HOLD |-> !tx_valid)
		else $error("frame offered during start-up hold");
	a_idle_rx: assert property (!wrote |-> rx_lost == '0 && rx_dig == '0)
		else $error("receive flag set before any setup");
	a_idle_tx: assert property (!wrote |-> !tx_valid)
		else $error("frame offered with all rates zero");
	a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_frame)
		&& $stable(tx_if))
		else $error("offered frame changed before taken");
	a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("write response late");
	a_aw_close: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
		else $error("address ready during write");
	a_wr_close: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid
		&& s_axi_awready && s_axi_wready)
		else $error("write channel not reopened");
	a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data late");
	a_rd_close: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid
		&& s_axi_arready)
		else $error("read channel not reopened");
endmodule : csps_mapper_assertions
bind csps_mapper csps_mapper_assertions #(.NRX(NRX), .MS_CYCLES(MS_CYCLES),
	.HOLD_MS(HOLD_MS)) chk_u (.clk(clk), .rstn(rstn),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .tx_valid(tx_valid),
	.tx_if(tx_if), .tx_frame(tx_frame), .tx_ready(tx_ready), .rx_lost(rx_lost),
	.rx_dig(rx_dig));
`default_nettype wire

// ---- tb/csps_mapper_tb.sv ----
// Self-checking bench for the CAN signal mapper
`timescale 1ns/1ps
`default_nettype none
module csps_mapper_tb import csps_pkg::*;;
	logic              clk = 1'b0, rstn = 1'b0;
	logic [9:0]        awaddr = '0, araddr = '0;
	logic              awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic              arvalid = 1'b0, rready = 1'b0;
	logic [31:0]       wdata = '0, rdata, rd_data;
	logic [3:0]        wstrb = 4'h0;
	logic [7:0]        supply_v = 8'h00;
	logic [17:0][15:0][15:0] ext_val = '0;
	logic              awready, wready, bvalid, arready, rvalid, tx_valid, tx_if, tx_ready;
	logic [1:0]        bresp, rresp, resp, rx_valid;
	csps_frame_t       tx_frame;
	csps_frame_t [1:0] rx_frame;
	logic [8:0]        rx_lost, rx_dig;
	int                n0, bad_count = 0, total_checks = 0;

	csps_mapper #(.MS_CYCLES(10), .HOLD_MS(2)) dut_u (.clk(clk), .rstn(rstn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .ext_val(ext_val),
		.supply_v(supply_v), .cpu_temp(8'h00), .rx_valid(rx_valid), .rx_frame(rx_frame),
		.tx_valid(tx_valid), .tx_if(tx_if), .tx_frame(tx_frame), .tx_ready(tx_ready),
		.rx_lost(rx_lost), .rx_dig(rx_dig));
	csps_can_node node_u (.clk(clk), .rx_valid(rx_valid), .rx_frame(rx_frame),
		.tx_valid(tx_valid), .tx_if(tx_if), .tx_frame(tx_frame), .tx_ready(tx_ready));

	initial begin
		forever #50 clk = ~clk;
	end

	task automatic stop_test();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : stop_test

	task automatic check(input string what, input logic [63:0] e, input logic [63:0] g);
		total_checks++;
		if (g !== e) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", what, e, g);
		end
	endtask : check

	task automatic wr(input int w, input logic [31:0] d);
		logic a, b;
		a = 1'b1;
		b = 1'b1;
		@(posedge clk);
		awaddr  <= 10'(w * 4);
		wdata   <= d;
		wstrb   <= 4'hF;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		while (a || b) begin
			@(posedge clk);
			if (a && awready) begin
				awvalid <= 1'b0;
				a = 1'b0;
			end
			if (b && wready) begin
				wvalid <= 1'b0;
				b = 1'b0;
			end
		end
		do @(posedge clk); while (!bvalid);
		bready <= 1'b0;
		resp = bresp;
	endtask : wr

	task automatic rd(input int w);
		@(posedge clk);
		araddr  <= 10'(w * 4);
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do @(posedge clk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge clk); while (!rvalid);
		rready  <= 1'b0;
		rd_data = rdata;
		resp = rresp;
	endtask : rd

	task automatic rxc(input int i, input logic [7:0] sa, raw, input logic [31:0] e);
		node_u.send(i, '{18'h0EF00, sa, 64'(raw) << 12});
		rd(64);
		check("rx value", e, rd_data);
	endtask : rxc

	initial begin
		#(100 * 5000);
		bad_count++;
		stop_test();
	end

	initial begin
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		repeat (3) @(posedge clk);
		rd(0);
		check("hold flag", '0, rd_data);
		wr(81, 32'h0000_0001);
		rd(255);
		check("unmapped read", {2'h3, 32'h0}, {resp, rd_data});
		wr(255, 32'hFFFF_FFFF);
		check("unmapped write", 2'h3, resp);
		wr(64, 32'h0000_FFFF);
		rd(64);
		check("rx status reset", '0, {resp, rd_data});
		wr(16, 32'h0014_2203);
		wr(17, 32'h0620_EF00);
		wr(18, 32'h0005_0200);
		wr(19, 32'h001E_0014);
		rxc(0, 8'h22, 8'h0A, 32'h0);
		rxc(1, 8'h33, 8'h0A, 32'h0);
		rxc(1, 8'h22, 8'h0A, 32'h0000_0019);
		rxc(1, 8'h22, 8'h0D, 32'h0002_001F);
		rxc(1, 8'h22, 8'h0A, 32'h0002_0019);
		check("dig pin", 1'b1, rx_dig[0]);
		rxc(1, 8'h22, 8'h07, 32'h0000_0013);
		repeat (260) @(posedge clk);
		check("lost pin", 9'h001, rx_lost);
		wr(16, 32'h0000_FF03);
		repeat (300) @(posedge clk);
		check("lost off", 9'h000, rx_lost);
		rxc(1, 8'h55, 8'h0A, 32'h0000_0019);
		wr(48, 32'h0000_2201);
		wr(49, 32'h0040_FF20);
		wr(50, 32'h0000_0100);
		wr(51, 32'hFFFF_FFF0);
		wr(21, 32'h0020_FF30);
		wr(22, 32'h0000_0100);
		node_u.send(0, '{18'h0FF20, 8'h44, 64'h1234});
		node_u.send(0, '{18'h0FF30, 8'h44, 64'hFF});
		rd(72);
		check("rx msg nine", 32'h1234, rd_data);
		rd(65);
		check("rx disabled", '0, rd_data);
		supply_v <= 8'h0D;
		wr(1, 32'h0000_0020);
		wr(2, 32'h0000_0005);
		wr(80, 32'h0100_FF10);
		wr(82, 32'h0188_030B);
		wr(83, 32'h0002_0100);
		wr(84, 32'h0308_0300);
		wr(85, 32'h0000_0100);
		wr(86, 32'h07E1_0C0E);
		wr(87, 32'h0000_0100);
		wr(88, 32'h0001_020B);
		wr(89, 32'h0000_0100);
		wr(90, 32'h0000_FF10);
		wr(91, 32'h0000_0032);
		wr(92, 32'h0408_040B);
		wr(93, 32'h0000_0200);
		wr(94, 32'h0508_0101);
		wr(95, 32'h0000_0100);
		ext_val[17][15] <= 16'h005A;
		wr(96, 32'h0608_1011);
		wr(97, 32'h0000_0100);
		node_u.slow <= 1'b1;
		wr(81, 32'h0000_0001);
		n0 = node_u.n_tx;
		repeat (50) @(posedge clk);
		check("tx count", 1'b1, (node_u.n_tx - n0) inside {[4:6]});
		check("tx data", 64'h805A_190A_0001_E001, node_u.got.data);
		check("tx pgn", 18'h0FF10, node_u.got.pgn);
		check("tx source address", 8'h00, node_u.got.sa);
		check("tx interface", 1'b1, node_u.got_if);
		wr(81, 32'h0000_0000);
		repeat (20) @(posedge clk);
		n0 = node_u.n_tx;
		repeat (50) @(posedge clk);
		check("silent group", 64'(n0), 64'(node_u.n_tx));
		rd(0);
		check("hold flag", 32'h1, rd_data);
		stop_test();
	end
endmodule : csps_mapper_tb
`default_nettype wire
